// file: pkg/host_cmd_pkg.sv
// constants for the host command register upper fields block
package host_cmd_pkg;
	localparam logic [11:0] cmd_off = 12'h000;
	localparam logic [11:0] irq_stat_off = 12'h004;
	localparam logic [11:0] irq_mask_off = 12'h008;
	localparam logic [11:0] sched_stat_off = 12'h00c;
	localparam int doorbell_bit = 6;
	localparam int light_reset_bit = 7;
	localparam int park_cnt_lo = 8;
	localparam int park_cnt_hi = 9;
	localparam int park_en_bit = 11;
	localparam int thresh_lo = 16;
	localparam int thresh_hi = 23;
	localparam logic [1:0] park_cnt_rst = 2'h3;
	localparam logic park_en_rst = 1'h1;
	localparam logic [7:0] thresh_rst = 8'h08;
	localparam logic [6:0] uframe_div_rst = 7'h00;
	// 125 us micro-frame at 50 MHz
	localparam int uframe_ns = 125000;
	localparam int clk_ns = 20;
	localparam int uframe_cycles = uframe_ns / clk_ns;
	// interrupt status / mask layout
	localparam int ev_advance = 0;
	localparam int ev_boundary = 1;
	localparam int num_ev = 2;
endpackage : host_cmd_pkg

// file: hw/host_cmd_upper.sv
// command register upper fields with doorbell handshake over apb
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1 - bit 6 doorbell asks for interrupt at threshold after next queue advance
// R2 - software rings the doorbell by writing one to bit 6
// R3 - cached schedule state evicted before advance flag is set
// R4 - controller clears doorbell only after setting the advance flag; the code clears it one edge before advance_flag rises
// R5 - bit 7 light reset is read only and reads zero
// R6 - bits 9:8 park count, read/write, reset 11b
// R7 - bit 11 park enable, read/write, reset 1b
// R8 - bits 23:16 interrupt threshold, read/write, reset 08h
// R9 - threshold codes 01h..40h give 1..64 micro-frame intervals
// R10 - software writes only listed threshold codes; others undefined
// R11 - reserved bits read zero and ignore writes
module host_cmd_upper #(
	parameter int uframe_len = host_cmd_pkg::uframe_cycles
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic queue_advanced,
	input wire logic cache_evicted,
	output logic evict_req,
	output logic [1:0] park_count,
	output logic park_enable,
	output logic [7:0] irq_threshold,
	output logic advance_flag,
	output logic irq
);
	// divider width follows the micro-frame length
	localparam int div_w = $clog2(uframe_len + 1);

	typedef enum logic [1:0] {
		idle,
		wait_adv,
		wait_evict,
		wait_bound
	} db_e;
	db_e db_state_reg;
	logic doorbell_reg;
	logic [1:0] park_cnt_reg;
	logic park_en_reg;
	logic [7:0] thresh_reg;
	logic [6:0] uframe_cnt_reg;
	logic [div_w-1:0] div_reg;
	logic [host_cmd_pkg::num_ev-1:0] stat_reg;
	logic [host_cmd_pkg::num_ev-1:0] mask_reg;
	logic [host_cmd_pkg::num_ev-1:0] ev_set;
	logic [host_cmd_pkg::num_ev-1:0] clr_ev;
	logic uframe_tick;
	logic boundary;
	logic access;
	logic wr;
	logic rd;
	logic sel_cmd;
	logic sel_stat;
	logic sel_mask;
	logic sel_sched;
	logic mapped;
	logic wr_cmd;
	logic wr_stat;
	logic wr_mask;
	logic ring;
	logic set_adv;
	logic evict_next;
	logic pready_next;
	logic pslverr_next;
	logic [31:0] rdata_next;

	////////////////////////////////////////////////////////////////////////
	// address decode shared by the write and error paths
	assign sel_cmd = (paddr == host_cmd_pkg::cmd_off);
	assign sel_stat = (paddr == host_cmd_pkg::irq_stat_off);
	assign sel_mask = (paddr == host_cmd_pkg::irq_mask_off);
	assign sel_sched = (paddr == host_cmd_pkg::sched_stat_off);
	assign mapped = sel_cmd || sel_stat || sel_mask || sel_sched;

	// a write lands only on the edge that samples pready high
	assign access = psel && penable;
	assign wr = access && pwrite && pready;
	assign rd = access && !pwrite;
	assign wr_cmd = wr && sel_cmd;
	assign wr_stat = wr && sel_stat;
	assign wr_mask = wr && sel_mask;
	assign clr_ev = {host_cmd_pkg::num_ev{wr_stat}} &
		pwdata[host_cmd_pkg::num_ev-1:0];
	// writing zero to the doorbell does nothing
	assign ring = wr_cmd && pwdata[host_cmd_pkg::doorbell_bit]; // R1
	assign pready_next = access && !pready;
	assign pslverr_next = access && !pready && !mapped;
	assign evict_next = (db_state_reg == wait_adv && queue_advanced) ||
		(db_state_reg == wait_evict && !cache_evicted); // R3

	////////////////////////////////////////////////////////////////////////
	// micro-frame tick and threshold boundary
	assign uframe_tick = (div_reg == div_w'(uframe_len - 1));
	// count + 1 >= code, so a threshold lowered to count + 1 or below ends the interval at the next tick
	assign boundary = uframe_tick &&
		({1'b0, uframe_cnt_reg} + 8'h01 >= thresh_reg); // R9
	assign set_adv = (db_state_reg == wait_bound) && boundary; // R1
	assign ev_set[host_cmd_pkg::ev_advance] = set_adv; // R3
	assign ev_set[host_cmd_pkg::ev_boundary] = boundary;

	// divider: a one-cycle tick per micro-frame, no second clock
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			div_reg <= '0;
		end else if (uframe_tick) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + div_w'(1);
		end
	end

	// interval counter restarts at each boundary
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			uframe_cnt_reg <= host_cmd_pkg::uframe_div_rst;
		end else if (boundary) begin
			uframe_cnt_reg <= host_cmd_pkg::uframe_div_rst;
		end else if (uframe_tick) begin
			uframe_cnt_reg <= uframe_cnt_reg + 7'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration fields, one flop group each
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			park_cnt_reg <= host_cmd_pkg::park_cnt_rst; // R6
		end else if (wr_cmd) begin
			park_cnt_reg <= pwdata[host_cmd_pkg::park_cnt_hi:
				host_cmd_pkg::park_cnt_lo]; // R6
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			park_en_reg <= host_cmd_pkg::park_en_rst; // R7
		end else if (wr_cmd) begin
			park_en_reg <= pwdata[host_cmd_pkg::park_en_bit]; // R7
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			thresh_reg <= host_cmd_pkg::thresh_rst; // R8
		end else if (wr_cmd) begin
			// unlisted codes are stored as written; timing then undefined
			thresh_reg <= pwdata[host_cmd_pkg::thresh_hi:
				host_cmd_pkg::thresh_lo]; // R8
		end
	end

	////////////////////////////////////////////////////////////////////////
	// doorbell bit: rung by software, cleared by the controller
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			doorbell_reg <= 1'b0;
		end else if (set_adv) begin
			// status bit and clear share an edge; the clear leads the advance_flag output by one cycle
			doorbell_reg <= 1'b0; // R4
		end else if (ring && db_state_reg == idle) begin
			doorbell_reg <= 1'b1; // R1
		end
	end

	// handshake: wait advance, wait eviction, wait boundary
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			db_state_reg <= idle;
		end else begin
			unique case (db_state_reg)
				idle: begin
					// a ring while a handshake runs is ignored
					if (ring) begin
						db_state_reg <= wait_adv;
					end
				end
				wait_adv: begin
					if (queue_advanced) begin
						db_state_reg <= wait_evict;
					end
				end
				wait_evict: begin
					if (cache_evicted) begin
						db_state_reg <= wait_bound; // R3
					end
				end
				wait_bound: begin
					if (set_adv) begin
						db_state_reg <= idle;
					end
				end
			endcase
		end
	end

	// evict request stands until the engine reports the eviction
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			evict_req <= 1'b0;
		end else begin
			evict_req <= evict_next; // R3
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky status and mask per event; a set wins over the clear
	for (genvar ev = 0; ev < host_cmd_pkg::num_ev; ev++) begin : g_event
		always_ff @(posedge core_clk) begin
			if (!resetn) begin
				stat_reg[ev] <= 1'b0;
			end else if (ev_set[ev]) begin
				stat_reg[ev] <= 1'b1;
			end else if (clr_ev[ev]) begin
				stat_reg[ev] <= 1'b0;
			end
		end

		always_ff @(posedge core_clk) begin
			if (!resetn) begin
				mask_reg[ev] <= 1'b0;
			end else if (wr_mask) begin
				mask_reg[ev] <= pwdata[ev];
			end
		end
	end

	// level interrupt, one cycle behind the status bits
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_reg & mask_reg);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			advance_flag <= 1'b0;
		end else begin
			advance_flag <= stat_reg[host_cmd_pkg::ev_advance]; // R3
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb read mux; reserved and light reset bits stay zero
	always_comb begin
		rdata_next = 32'h00000000; // R11
		unique case (paddr)
			host_cmd_pkg::cmd_off: begin
				rdata_next[host_cmd_pkg::doorbell_bit] = doorbell_reg;
				rdata_next[host_cmd_pkg::light_reset_bit] = 1'b0; // R5
				rdata_next[host_cmd_pkg::park_cnt_hi:
					host_cmd_pkg::park_cnt_lo] = park_cnt_reg;
				rdata_next[host_cmd_pkg::park_en_bit] = park_en_reg;
				rdata_next[host_cmd_pkg::thresh_hi:
					host_cmd_pkg::thresh_lo] = thresh_reg;
			end
			host_cmd_pkg::irq_stat_off: begin
				rdata_next[host_cmd_pkg::num_ev-1:0] = stat_reg;
			end
			host_cmd_pkg::irq_mask_off: begin
				rdata_next[host_cmd_pkg::num_ev-1:0] = mask_reg;
			end
			host_cmd_pkg::sched_stat_off: begin
				rdata_next[$bits(db_e)-1:0] = db_state_reg;
			end
			default: begin
				rdata_next = 32'h00000000;
			end
		endcase
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pready <= 1'b0;
		end else begin
			pready <= pready_next;
		end
	end

	// unmapped offsets answer with an error and the write is dropped
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= pslverr_next;
		end
	end

	// read data is latched once and stands while pready is high
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			prdata <= 32'h00000000;
		end else if (rd && !pready) begin
			prdata <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered copies for the schedule engine, one cycle behind
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			park_count <= host_cmd_pkg::park_cnt_rst; // R6
		end else begin
			park_count <= park_cnt_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			park_enable <= host_cmd_pkg::park_en_rst; // R7
		end else begin
			park_enable <= park_en_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			irq_threshold <= host_cmd_pkg::thresh_rst; // R8
		end else begin
			irq_threshold <= thresh_reg;
		end
	end
endmodule : host_cmd_upper

// file: verification/host_cmd_upper_props.sv
// assertions on the host command block ports
`timescale 1ns/1ns
module host_cmd_upper_props #(
	parameter int uframe_len = 4
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic queue_advanced,
	input wire logic cache_evicted,
	input wire logic evict_req,
	input wire logic [1:0] park_count,
	input wire logic park_enable,
	input wire logic [7:0] irq_threshold,
	input wire logic advance_flag,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence cmd_rd;
		pready && !pwrite && paddr == 12'h000;
	endsequence
	sequence cmd_wr;
		pready && pwrite && paddr == 12'h000;
	endsequence
	////////////////////////////////////////////////////////////////////////////
	a_rsv_zero: assert property (cmd_rd |-> prdata[31:24] == 8'h00
		&& prdata[15:12] == 4'h0 && !prdata[10] && !prdata[7])
		else $error("reserved bits read as one");
	// copies lag the field by one cycle, so look two edges on
	a_field_copy: assert property (cmd_wr |-> ##2
		park_count == $past(pwdata[9:8], 2) && park_enable == $past(pwdata[11], 2)
		&& irq_threshold == $past(pwdata[23:16], 2))
		else $error("field copy wrong");
	a_evict_cause: assert property ($rose(evict_req) |->
		$past(queue_advanced) || $past(queue_advanced, 2))
		else $error("evict without advance");
	a_evict_hold: assert property (evict_req && !cache_evicted |=> evict_req)
		else $error("evict request dropped early");
	a_flag_w1c: assert property ($fell(advance_flag) |->
		$past(pready && pwrite && paddr == 12'h004 && pwdata[0], 2))
		else $error("advance flag lost");
	a_pready_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("wait state wrong");
	a_err_map: assert property (pready |-> pslverr == !(paddr == 12'h000 ||
		paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00c))
		else $error("error response wrong");
	a_reset_vals: assert property (resetn && !$past(resetn) |->
		park_count == 2'h3 && park_enable && irq_threshold == 8'h08 && !irq)
		else $error("reset value wrong");
endmodule : host_cmd_upper_props
bind host_cmd_upper host_cmd_upper_props #(.uframe_len(uframe_len)) i_props (.*);

// file: verification/host_cmd_upper_tb.sv
// self-checking bench for the host command block
`timescale 1ns/1ns
module host_cmd_upper_tb;
	logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic queue_advanced = 0, cache_evicted = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic pready, pslverr, evict_req, park_enable, advance_flag, irq;
	logic [1:0] park_count;
	logic [7:0] irq_threshold;
	logic [7:0] codes [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
	int miscompares = 0, samples_checked = 0;
	always #10 core_clk = ~core_clk;
	host_cmd_upper #(.uframe_len(4)) i_host_cmd_upper (
		.core_clk(core_clk),
		.resetn(resetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.queue_advanced(queue_advanced),
		.cache_evicted(cache_evicted),
		.evict_req(evict_req),
		.park_count(park_count),
		.park_enable(park_enable),
		.irq_threshold(irq_threshold),
		.advance_flag(advance_flag),
		.irq(irq)
	);
	////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("checked %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	task automatic hang;
		miscompares++;
		$display("[FAIL] %0t wait ran out", $time);
		give_verdict();
	endtask : hang
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// idle edge after release so the next setup never collides
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n == 50) hang();
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge core_clk);
	endtask : apb
	task automatic wait_for(input int s);
		int n;
		for (n = 0; n < 200; n++) begin
			@(posedge core_clk);
			if ((s ? advance_flag : evict_req) === 1'h1) break;
		end
		if (n == 200) hang();
	endtask : wait_for
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge core_clk);
		resetn <= 1'h1;
		apb(0, 12'h000, 0);
		chk(rd, 32'h00080b00);
		chk({21'h0, park_count, park_enable, irq_threshold}, 32'h708);
		apb(1, 12'h000, 32'hff08ffbf);
		apb(0, 12'h000, 0);
		chk(rd, 32'h00080b00);
		apb(1, 12'h000, 32'h00010000);
		apb(0, 12'h000, 0);
		chk(rd, 32'h00010000);
		chk({29'h0, park_count, park_enable}, 32'h0);
		chk({31'h0, er}, 32'h0);
		foreach (codes[i]) begin
			apb(1, 12'h000, {8'h00, codes[i], 16'h0b00});
			apb(0, 12'h000, 0);
			chk(rd, {8'h00, codes[i], 16'h0b00});
			chk({24'h0, irq_threshold}, {24'h0, codes[i]});
		end
		$display("regs done");
		apb(0, 12'h010, 0);
		chk({er, rd[30:0]}, 32'h80000000);
		$display("map done");
		chk({31'h0, irq}, 32'h0);
		apb(1, 12'h008, 32'h1);
		apb(1, 12'h000, 32'h00010b40);
		apb(0, 12'h000, 0);
		chk(rd, 32'h00010b40);
		apb(0, 12'h00c, 0);
		chk(rd, 32'h00000001);
		queue_advanced <= 1'h1;
		wait_for(0);
		queue_advanced <= 1'h0;
		cache_evicted <= 1'h1;
		wait_for(1);
		cache_evicted <= 1'h0;
		chk({31'h0, evict_req}, 32'h0);
		apb(0, 12'h000, 0);
		chk(rd, 32'h00010b00);
		chk({31'h0, irq}, 32'h1);
		apb(0, 12'h004, 0);
		chk({31'h0, rd[0]}, 32'h1);
		apb(1, 12'h004, 32'h1);
		repeat (3) @(posedge core_clk);
		chk({30'h0, advance_flag, irq}, 32'h0);
		apb(0, 12'h00c, 0);
		chk(rd, 32'h00000000);
		$display("doorbell done");
		give_verdict();
	end
endmodule : host_cmd_upper_tb
